// ===== rtl/tldm_top.sv
// Three-channel transmit line driver and drive monitor with APB registers
//
// The implementer's own choices: the register addresses and the APB slave port.
module tldm_top
  import tldm_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              reg_mode,
  input  wire logic [NUM_CH-1:0] transmitter_on,
  input  wire logic [NUM_CH-1:0] bit_tick,
  input  wire logic [NUM_CH-1:0] tx_pos,
  input  wire logic [NUM_CH-1:0] tx_neg,
  input  wire logic [NUM_CH-1:0] monitor_in_pos,
  input  wire logic [NUM_CH-1:0] monitor_in_neg,
  output logic      [NUM_CH-1:0] line_out_pos,
  output logic      [NUM_CH-1:0] line_out_neg,
  output logic      [NUM_CH-1:0] line_out_pos_oe_n,
  output logic      [NUM_CH-1:0] line_out_neg_oe_n,
  output logic      [NUM_CH-1:0] drive_fault_flag,
  output logic                   irq
);

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  wire logic acc    = psel & penable;
  wire logic wr_acc = acc & pwrite;
  wire logic hit_ctrl = (paddr == ADDR_CTRL);
  wire logic hit_stat = (paddr == ADDR_STATUS);
  wire logic hit_evt  = (paddr == ADDR_EVENT);
  wire logic hit_mask = (paddr == ADDR_MASK);
  wire logic mapped   = hit_ctrl | hit_stat | hit_evt | hit_mask;

  logic [NUM_CH-1:0] txon_reg_q;
  logic [NUM_CH-1:0] intmon_q;
  logic [NUM_CH-1:0] evt_q;
  logic [NUM_CH-1:0] mask_q;
  logic [NUM_CH-1:0] fault_rise;
  logic [NUM_CH-1:0] fault_w;
  logic              regm_q;

  // Mode pin is a strap caught on every clock after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regm_q <= 1'b0;
    end else begin
      regm_q <= reg_mode;
    end
  end

  // ---------------------------------------------------------------
  // Control path selection
  // ---------------------------------------------------------------
  wire logic [NUM_CH-1:0] txon_eff = regm_q ? txon_reg_q : transmitter_on;
  // In pin mode the internal-monitor bits are held off
  wire logic [NUM_CH-1:0] use_int  = regm_q ? intmon_q : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txon_reg_q <= TXON_RESET;
      intmon_q   <= '0;
      mask_q     <= MASK_RESET;
    end else if (wr_acc && hit_ctrl) begin
      txon_reg_q <= pwdata[CTRL_TXON_LSB +: NUM_CH];
      intmon_q   <= pwdata[CTRL_INT_LSB +: NUM_CH];
    end else if (wr_acc && hit_mask) begin
      mask_q     <= pwdata[NUM_CH-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Sticky fault events, write one to clear; a new event wins
  // ---------------------------------------------------------------
  wire logic [NUM_CH-1:0] evt_clr = (wr_acc && hit_evt) ? pwdata[NUM_CH-1:0] : '0;
  wire logic [NUM_CH-1:0] evt_d   = (evt_q & ~evt_clr) | fault_rise;
  // Next mask, so that a mask write shows on irq in the same cycle as the mask
  wire logic [NUM_CH-1:0] mask_d  = (wr_acc && hit_mask) ? pwdata[NUM_CH-1:0] : mask_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_q <= '0;
      irq   <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq   <= |(evt_d & mask_d);
    end
  end

  // ---------------------------------------------------------------
  // Read data; one wait-free access phase, error on unmapped address
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {23'h0, regm_q, 1'b0, intmon_q, 1'b0, txon_reg_q} :
                  hit_stat ? {29'h0, fault_w} :
                  hit_evt  ? {29'h0, evt_q} :
                  hit_mask ? {29'h0, mask_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      tldm_line_t ln;
      tldm_sym_t  sym;
      tldm_sym_t  mon;
      assign sym.pos = tx_pos[g];
      assign sym.neg = tx_neg[g];
      assign mon.pos = monitor_in_pos[g];
      assign mon.neg = monitor_in_neg[g];
      tldm_channel u_ch (
        .pclk         (pclk),
        .presetn      (presetn),
        .bit_tick     (bit_tick[g]),
        .tx_sym       (sym),
        .tx_on        (txon_eff[g]),
        .use_internal (use_int[g]),
        .mon_in       (mon),
        .line_q       (ln),
        .fault_q      (fault_w[g]),
        .fault_rise   (fault_rise[g])
      );
      assign line_out_pos[g]      = ln.pos_o;
      assign line_out_neg[g]      = ln.neg_o;
      assign line_out_pos_oe_n[g] = ln.pos_oe_n;
      assign line_out_neg_oe_n[g] = ln.neg_oe_n;
      assign drive_fault_flag[g]  = fault_w[g];
    end
  endgenerate

  pin_mode_ext_a: assert property (@(posedge pclk) disable iff (!presetn)
    !regm_q |-> use_int == '0)
    else $error("internal monitor used in pin mode");
  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    |(evt_q & mask_q) |-> irq)
    else $error("interrupt low with pending event");

endmodule

// ===== rtl/tldm_pkg.sv
// Package for the transmit line driver and drive monitor block
package tldm_pkg;

  // ---------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH      = 3;
  localparam int unsigned SILENT_BITS = 128;
  localparam int unsigned CNT_W       = 8;
  localparam logic [CNT_W-1:0] SILENT_LIMIT = 8'h80;
  localparam logic [CNT_W-1:0] CNT_ZERO     = 8'h00;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_EVENT  = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0C;

  // Control register fields
  localparam int unsigned CTRL_TXON_LSB = 0;
  localparam int unsigned CTRL_INT_LSB  = 4;
  localparam int unsigned CTRL_REG_MODE = 8;

  localparam logic [2:0] TXON_RESET = 3'h0;
  localparam logic [2:0] MASK_RESET = 3'h0;

  // Bit-period symbol on one channel
  typedef struct packed {
    logic pos;
    logic neg;
  } tldm_sym_t;

  // Differential line pins, enables active low
  typedef struct packed {
    logic pos_o;
    logic neg_o;
    logic pos_oe_n;
    logic neg_oe_n;
  } tldm_line_t;

endpackage

// ===== rtl/tldm_channel.sv
// One channel: line driver and drive activity monitor
module tldm_channel
  import tldm_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic      bit_tick,
  input  tldm_sym_t      tx_sym,
  input  wire logic      tx_on,
  input  wire logic      use_internal,
  input  tldm_sym_t      mon_in,
  output tldm_line_t     line_q,
  output logic           fault_q,
  output logic           fault_rise
);

  // ---------------------------------------------------------------
  // Driver
  // ---------------------------------------------------------------
  // A symbol with both rails set is illegal; treat it as no pulse
  wire logic drv_pos = tx_sym.pos & ~tx_sym.neg;
  wire logic drv_neg = tx_sym.neg & ~tx_sym.pos;
  tldm_line_t line_d;

  always_comb begin
    line_d.pos_o    = drv_pos;
    line_d.neg_o    = drv_neg;
    line_d.pos_oe_n = ~tx_on;
    line_d.neg_oe_n = ~tx_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= '{pos_o: 1'b0, neg_o: 1'b0, pos_oe_n: 1'b1, neg_oe_n: 1'b1};
    end else begin
      line_q <= line_d;
    end
  end

  // ---------------------------------------------------------------
  // Monitor
  // ---------------------------------------------------------------
  // Internal path watches the driven pins, so a disabled driver counts as silent
  wire logic int_act = (line_q.pos_o ^ line_q.neg_o) & ~line_q.pos_oe_n;
  wire logic ext_act = mon_in.pos ^ mon_in.neg;
  wire logic active  = use_internal ? int_act : ext_act;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire logic at_limit = (cnt_q == SILENT_LIMIT);

  assign cnt_d = active ? CNT_ZERO :
                 (bit_tick && !at_limit) ? cnt_q + 8'h01 : cnt_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= CNT_ZERO;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  wire logic fault_d = (cnt_d == SILENT_LIMIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end

  assign fault_rise = fault_d & ~fault_q;

  tri_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !tx_on |=> line_q.pos_oe_n && line_q.neg_oe_n)
    else $error("line driver not off while transmitter off");
  pos_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_sym == 2'b10) |=> line_q.pos_o && !line_q.neg_o)
    else $error("positive pulse not driven");
  neg_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_sym == 2'b01) |=> !line_q.pos_o && line_q.neg_o)
    else $error("negative pulse not driven");
  idle_equal_a: assert property (@(posedge pclk) disable iff (!presetn)
    (tx_sym.pos == tx_sym.neg) |=> line_q.pos_o == line_q.neg_o)
    else $error("idle outputs differ");
  fault_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    active |=> !fault_q)
    else $error("fault flag high after activity");
  fault_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_q == SILENT_LIMIT - 8'h01) && bit_tick && !active |=> fault_q)
    else $error("fault flag late");
  count_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
    fault_q |-> cnt_q == SILENT_LIMIT)
    else $error("fault flag before silence limit");
  ext_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    use_internal && !int_act |=> cnt_q != CNT_ZERO || $past(cnt_q) == CNT_ZERO
      || $past(cnt_q) == SILENT_LIMIT)
    else $error("monitor inputs used in internal mode");

endmodule

// ===== testbench/tldm_line_model.sv
// Transformer and cable model that feeds the line back to the monitor inputs
module tldm_cable_model (
  input  wire logic       pclk,
  input  wire logic       cut,
  input  wire logic [2:0] line_pos,
  input  wire logic [2:0] line_neg,
  input  wire logic [2:0] pos_oe_n,
  input  wire logic [2:0] neg_oe_n,
  output logic      [2:0] mon_pos,
  output logic      [2:0] mon_neg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // Line coupling
  // ---------------------------------------------------------------
  logic       alt_q = 1'b0;
  logic [2:0] driven;
  // An undriven or cut pair shows no differential, but never a stale level
  always @(posedge pclk) alt_q <= ~alt_q;
  assign driven  = ~(pos_oe_n | neg_oe_n) & {3{~cut}};
  assign mon_pos = (line_pos & driven) | ({3{alt_q}} & ~driven);
  assign mon_neg = (line_neg & driven) | ({3{alt_q}} & ~driven);
endmodule

// ===== testbench/test_tx_line_driver_monitor.sv
// Self-checking bench for the three-channel line driver and drive monitor
module test_tx_line_driver_monitor;
  import tldm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, reg_mode, cut, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  txon, tick, tpos, tneg, mpos, mneg, lpos, lneg, poe, noe, flag;
  int          mismatches, samples_checked;
  tldm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reg_mode(reg_mode), .transmitter_on(txon), .bit_tick(tick),
    .tx_pos(tpos), .tx_neg(tneg), .monitor_in_pos(mpos), .monitor_in_neg(mneg),
    .line_out_pos(lpos), .line_out_neg(lneg), .line_out_pos_oe_n(poe),
    .line_out_neg_oe_n(noe), .drive_fault_flag(flag), .irq(irq));
  tldm_cable_model cable (.pclk(pclk), .cut(cut), .line_pos(lpos), .line_neg(lneg),
    .pos_oe_n(poe), .neg_oe_n(noe), .mon_pos(mpos), .mon_neg(mneg));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic err);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer, never a fixed count; only the watchdog ends a hang
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    check({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk); tick <= 3'h7;
      @(posedge pclk); tick <= 3'h0;
    end
    repeat (2) @(posedge pclk);
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic regs_after_reset;
    apb(1'b0, ADDR_CTRL, 32'h0, 1'b0);   check(rd, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0, 1'b0); check(rd, 32'h0);
    apb(1'b0, ADDR_MASK, 32'h0, 1'b0);   check(rd, 32'h0);
    apb(1'b1, 8'h10, 32'h7, 1'b1);
    apb(1'b0, 8'h10, 32'h0, 1'b1);       check(rd, 32'h0);
  endtask
  task automatic polarity;
    txon <= 3'h7; tpos <= 3'b101; tneg <= 3'b110;
    repeat (3) @(posedge pclk);
    check({29'h0, lpos[0], lneg[0], poe[0]}, 32'h4);
    check({29'h0, lpos[1], lneg[1], noe[1]}, 32'h2);
    check({31'h0, lpos[2] ^ lneg[2]}, 32'h0);
    txon <= 3'b010;
    repeat (2) @(posedge pclk);
    check({26'h0, poe, noe}, 32'h2D);
    txon <= 3'h7; tpos <= 3'h0; tneg <= 3'h0;
  endtask
  task automatic silence_and_irq;
    ticks(127);
    check({29'h0, flag}, 32'h0);
    ticks(1);
    check({29'h0, flag}, 32'h7);
    apb(1'b0, ADDR_EVENT, 32'h0, 1'b0); check(rd, 32'h7);
    apb(1'b0, ADDR_STATUS, 32'h0, 1'b0); check(rd, 32'h7);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, ADDR_MASK, 32'h2, 1'b0); @(posedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, ADDR_EVENT, 32'h2, 1'b0); @(posedge pclk);
    check({31'h0, irq}, 32'h0);
    tpos <= 3'h7; repeat (4) @(posedge pclk);
    check({29'h0, flag}, 32'h0);
  endtask
  task automatic internal_watch;
    cut <= 1'b1; reg_mode <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h77, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0, 1'b0); check(rd, 32'h177);
    ticks(130);
    check({29'h0, flag}, 32'h0);
    // Transmitter turn-off lands at the write edge, the pins follow one edge later
    apb(1'b1, ADDR_CTRL, 32'h70, 1'b0); repeat (2) @(posedge pclk);
    check({29'h0, poe}, 32'h7);
    ticks(128);
    check({29'h0, flag}, 32'h7);
    reg_mode <= 1'b0;
    ticks(130);
    check({29'h0, flag}, 32'h7);
  endtask
  // ---------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, reg_mode, cut} = 6'h0;
    paddr = 8'h00; pwdata = 32'h0; rd = 32'h0;
    {txon, tick, tpos, tneg} = 12'h000;
    mismatches = 0; samples_checked = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    regs_after_reset();
    polarity();
    silence_and_irq();
    internal_watch();
    wrap_up();
  end
  initial begin
    #(20 * 10000);
    mismatches++;
    wrap_up();
  end
endmodule
